// file: common/lcd_ctrl_pkg.sv
package lcd_ctrl_pkg;

	localparam int DISPLAY_DEPTH = 80;
	localparam int ADDR_WIDTH = 7;
	localparam int COMMONS = 18;
	localparam int SEGMENTS = 80;
	localparam int FONT_ADDR_WIDTH = 13;

	localparam logic [7:0] SPACE_CODE = 8'h20;
	localparam logic [6:0] LAST_ADDRESS = 7'h4f;
	localparam logic [7:0] CLEAR_OSC_CYCLES = 8'h55;
	localparam logic [7:0] OSC_DIVIDE = 8'h04;

	// Instruction groups in data[7:4]; data[7] set means set address
	localparam logic [3:0] GROUP_MISC = 4'h0;
	localparam logic [3:0] GROUP_DRIVER = 4'h1;
	localparam logic [3:0] GROUP_POWER = 4'h2;
	localparam logic [3:0] GROUP_ENTRY = 4'h3;
	localparam logic [3:0] CMD_CLEAR = 4'h1;
	localparam logic [3:0] CMD_HOME = 4'h2;
	localparam logic [3:0] CMD_START_OSC = 4'h3;

	// Field positions inside the instruction byte
	localparam int POS_SEG_SHIFT = 0;
	localparam int POS_COM_SHIFT = 1;
	localparam int POS_STANDBY = 0;
	localparam int POS_SLEEP = 1;
	localparam int POS_AMPLIFIER = 2;
	localparam int POS_INC = 0;
	localparam int POS_BANK = 1;

	// Values after reset
	localparam logic RESET_INC = 1'b1;
	localparam logic RESET_OSC_RUN = 1'b1;

	typedef struct packed {
		logic write_strobe;
		logic register_select;
		logic [7:0] data;
	} host_write_t;

	typedef struct packed {
		logic increment;
		logic bank;
		logic common_shift_direction;
		logic segment_shift_direction;
		logic amplifier_enable;
		logic sleep_request;
		logic standby_request;
		logic osc_running;
	} settings_t;

endpackage

// file: hw/lcd_instruction_power_control.sv
module lcd_instruction_power_control (
	input wire logic clock, // 100 MHz system clock
	input wire logic sys_rst, // Asynchronous reset, active high
	input wire lcd_ctrl_pkg::host_write_t host, // Host write strobe, select, byte
	input wire logic [lcd_ctrl_pkg::ADDR_WIDTH-1:0] scan_address, // Glyph to draw
	input wire logic [2:0] scan_row, // Raster row to draw
	input wire logic [7:0] font_rom_data, // Word read from font ROM
	input wire logic [lcd_ctrl_pkg::COMMONS-1:0] common_logical, // Commons, natural order
	input wire logic [lcd_ctrl_pkg::SEGMENTS-1:0] segment_logical, // Segments, natural order
	output logic busy, // Clear display in progress
	output logic [lcd_ctrl_pkg::ADDR_WIDTH-1:0] address_counter, // Write address
	output lcd_ctrl_pkg::settings_t settings, // Current settings
	output logic [lcd_ctrl_pkg::FONT_ADDR_WIDTH-1:0] font_rom_address, // To font ROM
	output logic [4:0] row_pixels, // Row dots, one is dark
	output logic [lcd_ctrl_pkg::COMMONS-1:0] common_out, // Common drivers
	output logic [lcd_ctrl_pkg::SEGMENTS-1:0] segment_out // Segment drivers
);

	typedef struct packed {
		logic busy;
		logic [7:0] clear_count;
		logic [7:0] osc_div;
		logic [lcd_ctrl_pkg::ADDR_WIDTH-1:0] address;
		lcd_ctrl_pkg::settings_t set;
		logic [lcd_ctrl_pkg::FONT_ADDR_WIDTH-1:0] font_addr;
		logic user_glyph;
		logic [4:0] pixels;
		logic [lcd_ctrl_pkg::COMMONS-1:0] com;
		logic [lcd_ctrl_pkg::SEGMENTS-1:0] seg;
	} state_t;

	state_t state;
	state_t next_state;

	logic [7:0] display_memory [lcd_ctrl_pkg::DISPLAY_DEPTH];
	logic mem_we;
	logic [lcd_ctrl_pkg::ADDR_WIDTH-1:0] mem_addr;
	logic [7:0] mem_data;
	logic [7:0] glyph_code;
	logic osc_tick;

	// Codes whose glyphs lie in the user region; their rows are drawn blank instead of read from ROM
	function automatic logic in_user_region(input logic bank, input logic [7:0] code);
		logic low;
		logic high;
		low = (code[7:4] == 4'h0) || (bank && code[7:4] == 4'h1);
		high = bank && (code[7:4] == 4'h8 || code[7:4] == 4'h9);
		return low || high;
	endfunction

	// Step with wrap over the populated part of display memory
	function automatic logic [lcd_ctrl_pkg::ADDR_WIDTH-1:0] step_address(
		input logic [lcd_ctrl_pkg::ADDR_WIDTH-1:0] addr,
		input logic up
	);
		logic [lcd_ctrl_pkg::ADDR_WIDTH-1:0] result;
		if (up) begin
			result = (addr >= lcd_ctrl_pkg::LAST_ADDRESS) ? '0 : addr + 7'h01;
		end else begin
			result = (addr == '0) ? lcd_ctrl_pkg::LAST_ADDRESS : addr - 7'h01;
		end
		return result;
	endfunction

	assign glyph_code = display_memory[scan_address];
	// Oscillator stands still in standby, so no clear timing can advance there
	assign osc_tick = state.set.osc_running && !state.set.standby_request
		&& (state.osc_div == lcd_ctrl_pkg::OSC_DIVIDE - 8'h01);

	always_comb begin
		logic accept;
		logic is_power;
		logic is_start;
		logic [3:0] group;
		next_state = state;
		mem_we = 1'b0;
		mem_addr = state.address;
		mem_data = host.data;
		group = host.data[7:4];
		is_power = !host.register_select && !host.data[7] && group == lcd_ctrl_pkg::GROUP_POWER;
		is_start = !host.register_select && group == lcd_ctrl_pkg::GROUP_MISC
			&& host.data[3:0] == lcd_ctrl_pkg::CMD_START_OSC;
		accept = host.write_strobe;

		if (!state.set.osc_running || state.set.standby_request) begin
			next_state.osc_div = '0;
		end else if (osc_tick) begin
			next_state.osc_div = '0;
		end else begin
			next_state.osc_div = state.osc_div + 8'h01;
		end

		if (state.busy) begin
			accept = 1'b0;
		end
		if (state.set.standby_request && !(is_power || is_start)) begin
			accept = 1'b0;
		end
		if (state.set.sleep_request && !is_power) begin
			accept = 1'b0;
		end

		if (state.busy && osc_tick) begin
			if (state.clear_count < 8'(lcd_ctrl_pkg::DISPLAY_DEPTH)) begin
				mem_we = 1'b1;
				mem_addr = state.clear_count[lcd_ctrl_pkg::ADDR_WIDTH-1:0];
				mem_data = lcd_ctrl_pkg::SPACE_CODE;
			end
			if (state.clear_count == lcd_ctrl_pkg::CLEAR_OSC_CYCLES - 8'h01) begin
				next_state.busy = 1'b0;
				next_state.address = '0;
			end
			next_state.clear_count = state.clear_count + 8'h01;
		end

		// select between data and instruction register
		if (accept && host.register_select) begin
			mem_we = 1'b1;
			mem_addr = state.address;
			mem_data = host.data;
			next_state.address = step_address(state.address, state.set.increment);
		end else if (accept && host.data[7]) begin
			next_state.address = host.data[lcd_ctrl_pkg::ADDR_WIDTH-1:0];
		end else if (accept) begin
			unique case (group)
				lcd_ctrl_pkg::GROUP_MISC: begin
					if (host.data[3:0] == lcd_ctrl_pkg::CMD_CLEAR) begin
						next_state.busy = 1'b1;
						next_state.clear_count = '0;
						next_state.set.increment = 1'b1;
					end else if (host.data[3:0] == lcd_ctrl_pkg::CMD_HOME) begin
						next_state.address = '0;
					end else if (is_start) begin
						next_state.set.osc_running = 1'b1;
					end
				end
				lcd_ctrl_pkg::GROUP_DRIVER: begin
					next_state.set.common_shift_direction = host.data[lcd_ctrl_pkg::POS_COM_SHIFT];
					next_state.set.segment_shift_direction = host.data[lcd_ctrl_pkg::POS_SEG_SHIFT];
				end
				lcd_ctrl_pkg::GROUP_POWER: begin
					next_state.set.amplifier_enable = host.data[lcd_ctrl_pkg::POS_AMPLIFIER];
					next_state.set.sleep_request = host.data[lcd_ctrl_pkg::POS_SLEEP];
					next_state.set.standby_request = host.data[lcd_ctrl_pkg::POS_STANDBY];
					if (host.data[lcd_ctrl_pkg::POS_STANDBY]) begin
						next_state.set.osc_running = 1'b0;
					end
				end
				lcd_ctrl_pkg::GROUP_ENTRY: begin
					next_state.set.increment = host.data[lcd_ctrl_pkg::POS_INC];
					next_state.set.bank = host.data[lcd_ctrl_pkg::POS_BANK];
				end
				default: begin
				end
			endcase
		end

		next_state.font_addr = {state.set.bank, glyph_code, 1'b0, scan_row};
		next_state.user_glyph = in_user_region(state.set.bank, glyph_code);
		// only low five bits are dots
		next_state.pixels = state.user_glyph ? 5'h00 : font_rom_data[4:0];

		for (int i = 0; i < lcd_ctrl_pkg::COMMONS; i++) begin
			next_state.com[i] = state.set.common_shift_direction
				? common_logical[lcd_ctrl_pkg::COMMONS-1-i] : common_logical[i];
		end
		for (int i = 0; i < lcd_ctrl_pkg::SEGMENTS; i++) begin
			next_state.seg[i] = state.set.segment_shift_direction
				? segment_logical[lcd_ctrl_pkg::SEGMENTS-1-i] : segment_logical[i];
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			state <= '0;
			state.set.increment <= lcd_ctrl_pkg::RESET_INC;
			state.set.osc_running <= lcd_ctrl_pkg::RESET_OSC_RUN;
		end else begin
			state <= next_state;
		end
	end

	// Memory is left without reset; contents are undefined until cleared or written
	always_ff @(posedge clock) begin
		if (mem_we) begin
			display_memory[mem_addr] <= mem_data;
		end
	end

	assign busy = state.busy;
	assign address_counter = state.address;
	assign settings = state.set;
	assign font_rom_address = state.font_addr;
	assign row_pixels = state.pixels;
	assign common_out = state.com;
	assign segment_out = state.seg;

endmodule

// file: tb/lcd_instruction_power_control_assertions.sv
module lcd_ipc_checker (
	input wire logic clock, // System clock
	input wire logic sys_rst, // Reset
	input wire lcd_ctrl_pkg::host_write_t host, // Host write
	input wire logic [2:0] scan_row, // Row drawn
	input wire logic [7:0] font_rom_data, // ROM word
	input wire logic busy, // Clear running
	input wire logic [6:0] address_counter, // Write address
	input wire lcd_ctrl_pkg::settings_t settings, // Settings
	input wire logic [12:0] font_rom_address, // ROM address
	input wire logic [4:0] row_pixels // Row dots
);
	logic [9:0] busy_len;
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			busy_len <= 10'h000;
		end else begin
			busy_len <= busy ? busy_len + 10'h001 : 10'h000;
		end
	end
	sequence clear_taken;
		host.write_strobe && !host.register_select && host.data == 8'h01 && !busy
			&& !settings.sleep_request && !settings.standby_request;
	endsequence
	sequence data_taken;
		host.write_strobe && host.register_select && !busy && !settings.sleep_request
			&& !settings.standby_request;
	endsequence
	bank_bit_a: assert property (!$past(sys_rst) |-> font_rom_address[12] == $past(settings.bank))
		else $error("font bank bit wrong");
	row_field_a: assert property (!$past(sys_rst) |-> font_rom_address[2:0] == $past(scan_row))
		else $error("font row field wrong");
	gap_bit_a: assert property (font_rom_address[3] == 1'b0)
		else $error("font gap bit set");
	pixels_a: assert property (!$past(sys_rst) && $past(font_rom_address[11:4]) inside {[8'h20:8'h7f]}
		|-> row_pixels == $past(font_rom_data[4:0])) else $error("row pixels wrong");
	user_rows_a: assert property (!$past(sys_rst) && $past(font_rom_address[11:4]) < 8'h10
		|-> row_pixels == 5'h00) else $error("user code pixels not blank");
	step_a: assert property (data_taken ##0 (address_counter != 7'h00 && address_counter != 7'h4f)
		|=> address_counter == ($past(settings.increment) ? $past(address_counter) + 7'h01
		: $past(address_counter) - 7'h01)) else $error("address step wrong");
	clear_start_a: assert property (clear_taken |=> busy && settings.increment)
		else $error("clear did not start");
	clear_len_a: assert property ($fell(busy) |-> busy_len inside {[10'd337:10'd341]})
		else $error("clear length wrong");
	clear_end_a: assert property ($fell(busy) |-> address_counter == 7'h00)
		else $error("clear left address nonzero");
	busy_lock_a: assert property (busy && host.write_strobe |=> $stable(settings))
		else $error("write taken while busy");
	sleep_lock_a: assert property (settings.sleep_request && host.write_strobe
		&& (host.register_select || host.data[7:4] != 4'h2)
		|=> $stable(settings) && $stable(address_counter)) else $error("write taken asleep");
endmodule

bind lcd_instruction_power_control lcd_ipc_checker u_checker (.clock, .sys_rst, .host,
	.scan_row, .font_rom_data, .busy, .address_counter, .settings, .font_rom_address,
	.row_pixels);

// file: tb/host_model.sv
module host_model (
	input wire logic clock, // System clock
	output lcd_ctrl_pkg::host_write_t host // Writes toward the block
);
	timeunit 1ns;
	timeprecision 1ps;
	initial host = '0;
	task automatic wr(input logic sel, input logic [7:0] d);
		@(posedge clock);
		host <= {1'b1, sel, d};
	endtask
	task automatic idle();
		@(posedge clock);
		host.write_strobe <= 1'b0;
		// Released bus must not keep showing the last byte
		host.data <= ~host.data;
		#1;
	endtask
endmodule

// file: tb/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic [6:0] scan_address = 7'h00;
	logic [2:0] scan_row = 3'h0;
	logic [17:0] common_logical = 18'h00001;
	logic [79:0] segment_logical = 80'h1;
	logic [7:0] font_rom_data;
	lcd_ctrl_pkg::host_write_t host;
	lcd_ctrl_pkg::settings_t settings;
	logic busy;
	logic [6:0] address_counter;
	logic [12:0] font_rom_address;
	logic [4:0] row_pixels;
	logic [17:0] common_out;
	logic [79:0] segment_out;
	int num_errors = 0;
	int n_tests = 0;
	int i;
	assign font_rom_data = {3'b000, font_rom_address[8:4] ^ {2'b00, font_rom_address[2:0]}};
	initial forever #5 clock = ~clock;
	host_model u_host (.clock, .host);
	lcd_instruction_power_control u_dut (.clock, .sys_rst, .host, .scan_address, .scan_row,
		.font_rom_data, .common_logical, .segment_logical, .busy, .address_counter, .settings,
		.font_rom_address, .row_pixels, .common_out, .segment_out);
	task automatic chk(input string n, input logic [19:0] e, input logic [19:0] s);
		n_tests++;
		if (s !== e) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic conclude();
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic op(input logic sel, input logic [7:0] d);
		u_host.wr(sel, d);
		u_host.idle();
	endtask
	task automatic peek(input logic [6:0] a, input logic [2:0] r);
		@(posedge clock);
		scan_address <= a;
		scan_row <= r;
		@(posedge clock);
		#1;
	endtask
	initial begin
		repeat (3) @(posedge clock);
		sys_rst <= 1'b0;
		@(posedge clock);
		#1;
		chk("settings", 20'h81, settings);
		op(1'b0, 8'h30);
		op(1'b0, 8'h01);
		chk("busy", 20'h1, busy);
		// Host holds off until the clear finishes
		for (i = 0; i < 400 && busy !== 1'b0; i++) @(posedge clock);
		#1;
		if (i == 400) begin
			num_errors++;
			conclude();
		end
		chk("clear_len", 20'h1, i >= 336 && i <= 341);
		chk("ac", 20'h0, address_counter);
		chk("increment", 20'h1, settings.increment);
		peek(7'h00, 3'h0);
		chk("code0", 20'h20, font_rom_address[11:4]);
		peek(7'h4f, 3'h0);
		chk("code79", 20'h20, font_rom_address[11:4]);
		op(1'b0, 8'hce);
		u_host.wr(1'b1, 8'h41);
		u_host.wr(1'b1, 8'h42);
		u_host.idle();
		chk("ac_wrap", 20'h0, address_counter);
		peek(7'h4e, 3'h5);
		chk("code78", 20'h41, font_rom_address[11:4]);
		peek(7'h4f, 3'h5);
		chk("code79", 20'h42, font_rom_address[11:4]);
		chk("row", 20'h5, font_rom_address[2:0]);
		chk("gap", 20'h0, font_rom_address[3]);
		@(posedge clock);
		#1;
		chk("pixels", 20'h07, row_pixels);
		op(1'b0, 8'h30);
		op(1'b1, 8'h05);
		chk("ac_dec", 20'h4f, address_counter);
		peek(7'h00, 3'h2);
		@(posedge clock);
		#1;
		chk("user_row", 20'h0, row_pixels);
		op(1'b0, 8'h02);
		chk("home", 20'h0, address_counter);
		peek(7'h4e, 3'h0);
		chk("kept", 20'h41, font_rom_address[11:4]);
		op(1'b0, 8'h13);
		@(posedge clock);
		#1;
		chk("com_rev", 20'h20000, common_out);
		chk("seg_rev", 20'h2, segment_out[79:78]);
		op(1'b0, 8'h10);
		@(posedge clock);
		#1;
		chk("com_nat", 20'h1, common_out);
		chk("seg_nat", 20'h1, segment_out[1:0]);
		op(1'b0, 8'h24);
		chk("amp_on", 20'h1, settings.amplifier_enable);
		op(1'b0, 8'h26);
		op(1'b1, 8'h77);
		chk("sleep_ac", 20'h0, address_counter);
		op(1'b0, 8'h31);
		chk("sleep_inc", 20'h0, settings.increment);
		op(1'b0, 8'h24);
		chk("awake", 20'h0, settings.sleep_request);
		op(1'b0, 8'h25);
		chk("osc_off", 20'h0, settings.osc_running);
		op(1'b0, 8'h85);
		chk("stb_ac", 20'h0, address_counter);
		op(1'b0, 8'h03);
		chk("osc_on", 20'h1, settings.osc_running);
		// the model oscillator settles at once; eight idle cycles pass before the power write follows here
		repeat (8) @(posedge clock);
		op(1'b0, 8'h20);
		chk("stb_amp", 20'h0, {settings.amplifier_enable, settings.standby_request});
		op(1'b0, 8'h33);
		peek(7'h4e, 3'h0);
		chk("bank", 20'h1, font_rom_address[12]);
		conclude();
	end
endmodule
